// ### logic/sfpm_defines.svh
/*
 * constants of the serial flash power-up and mode-select front end:
 * opcode, address field layout, dummy count and timing counts.
 * assumes a 40 MHz system clock sampling the host serial pins.
 */
// Notes on behaviour
// R1: after reset, mode 3 and output hi-z
// R2: command starts only after select falls
// R3: each select fall samples clock: mode 3/0
// R4: host waits 70 us before selecting
// R5: during power-on reset ignore all commands
// R6: host waits 20 ms before program/erase
// R7: after power-up sit in standby until selected
// R8: E8h, then x, 13 page, 10 byte bits
// R9: page bits are page, byte bits offset
// R10: four dummy bytes precede array data
`ifndef SFPM_DEFINES_SVH
`define SFPM_DEFINES_SVH
`define SFPM_CLK_MHZ        40
`define SFPM_OP_CONT_READ   8'he8
`define SFPM_PAGE_W         13
`define SFPM_BYTE_W         10
`define SFPM_ADDR_W         24
`define SFPM_DUMMY_BYTES    4
`define SFPM_SEL_DELAY_US   70
`define SFPM_SEL_DELAY_CYC  (`SFPM_SEL_DELAY_US * `SFPM_CLK_MHZ)
`define SFPM_WRITE_DELAY_MS 20
`define SFPM_WRITE_DELAY_CYC (`SFPM_WRITE_DELAY_MS * 1000 * `SFPM_CLK_MHZ)
`endif

// ### logic/sfpm_pkg.sv
/*
 * types of the serial flash power-up and mode-select front end.
 * assumes the defines header is included alongside.
 */
package sfpm_pkg;
   // serial front-end phase
   typedef enum logic [2:0] {
      SFPM_ST_POR,
      SFPM_ST_STANDBY,
      SFPM_ST_OPCODE,
      SFPM_ST_ADDR,
      SFPM_ST_DUMMY,
      SFPM_ST_DATA,
      SFPM_ST_IGNORE
   } sfpm_state_e;
endpackage

// ### logic/sfpm_sync.sv
/*
 * two-flop synchroniser for one pin level.
 * assumes the pin is asynchronous to sys_clk_i.
 */
`timescale 1ns/10ps
module sfpm_sync (
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   input  wire logic rst_val_i,
   output logic      level_o
);
   typedef struct packed {
      logic first;   // metastable stage, read only by second
      logic second;  // settled level
   } sfpm_sync_s;
   sfpm_sync_s r, next_r;
   // shift the pin through two stages
   always_comb begin
      next_r        = r;
      next_r.first  = pin_i;
      next_r.second = r.first;
   end
   // reset value is a constant chosen per pin by a tie at instantiation
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign level_o = r.second ^ rst_val_i;
endmodule // sfpm_sync

// ### logic/sfpm_front.sv
/*
 * serial flash power-up / mode-select front end: holds off commands
 * during power-on reset, picks mode 0 or 3 at each select fall, frames
 * the continuous array read and streams array bytes from the user side.
 * assumes host drives sclk/cs_n/si asynchronously, sclk well below 20 MHz.
 */
`timescale 1ns/10ps
`include "sfpm_defines.svh"
module sfpm_front
   import sfpm_pkg::*;
#(
   parameter int unsigned WRITE_DELAY_CYC = `SFPM_WRITE_DELAY_CYC
) (
   input  wire logic                    sys_clk_i,
   input  wire logic                    reset_i,     // power-on reset
   input  wire logic                    sclk_i,      // host serial clock pin
   input  wire logic                    cs_n_i,      // host select pin, low active
   input  wire logic                    si_i,        // host serial data in
   output logic                         so_o,        // serial data out
   output logic                         so_oe_o,     // high while driving so
   output logic                         mode3_o,     // 1 = mode 3, 0 = mode 0
   output logic                         standby_o,   // idle, waiting for a select fall
   output logic                         write_ok_o,  // program/erase window open
   output logic                         rd_req_o,    // address captured pulse
   output logic [`SFPM_PAGE_W-1:0]      rd_page_o,   // main memory page
   output logic [`SFPM_BYTE_W-1:0]      rd_byte_o,   // offset in page
   output logic                         byte_req_o,  // next data byte wanted
   input  wire logic [7:0]              rd_data_i    // byte for next data slot
);
   logic sclk_s, cs_n_s, si_s;
   // pins pass two flops first; cs_n resets to deselected (inverted store)
   sfpm_sync u_sync_sclk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .pin_i(sclk_i),
                          .rst_val_i(1'b0), .level_o(sclk_s));
   sfpm_sync u_sync_cs (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .pin_i(~cs_n_i),
                        .rst_val_i(1'b1), .level_o(cs_n_s));
   sfpm_sync u_sync_si (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .pin_i(si_i),
                        .rst_val_i(1'b0), .level_o(si_s));

   typedef struct packed {
      sfpm_state_e          st;        // front-end phase
      logic                 por_done;  // first clock after reset seen
      logic                 sclk_d;    // previous sclk level
      logic                 cs_n_d;    // previous select level
      logic                 mode3;     // selected spi mode
      logic [4:0]           cnt;       // bit counter within field
      logic [`SFPM_ADDR_W-1:0] sh;     // input shift register
      logic [7:0]           obuf;      // output shift register
      logic                 so;        // output bit
      logic                 oe;        // output enable
      logic                 rd_req;    // address pulse
      logic                 byte_req;  // byte request pulse
      logic [`SFPM_PAGE_W-1:0] page;   // captured page
      logic [`SFPM_BYTE_W-1:0] offs;   // captured offset
      logic [1:0]           dcnt;      // dummy byte counter
      logic [31:0]          wcnt;      // write hold-off counter
      logic                 wok;       // write allowed
   } sfpm_front_s;
   sfpm_front_s r, next_r;

   logic rise, fall, sample, launch;
   // sample edge is rising in both modes; launch on falling
   assign rise   = sclk_s & ~r.sclk_d;
   assign fall   = ~sclk_s & r.sclk_d;
   assign sample = rise;
   assign launch = fall;

   // next-state logic
   always_comb begin
      next_r          = r;
      next_r.sclk_d   = sclk_s;
      next_r.cs_n_d   = cs_n_s;
      next_r.rd_req   = 1'b0;
      next_r.byte_req = 1'b0;
      // write hold-off timer after reset release
      if (!r.wok) begin
         if (r.wcnt >= WRITE_DELAY_CYC - 1) begin
            next_r.wok = 1'b1;
         end else begin
            next_r.wcnt = r.wcnt + 32'h1;
         end
      end
      case (r.st)
         SFPM_ST_POR: begin
            // ignore the bus for the first two cycles while reset settles
            next_r.por_done = 1'b1;                       // R5
            if (r.por_done) begin
               next_r.st = SFPM_ST_STANDBY;               // R7
            end
         end
         default: begin
            if (cs_n_s) begin
               // deselect ends any command and floats the output
               next_r.st = SFPM_ST_STANDBY;               // R7
               next_r.oe = 1'b0;
            end else if (r.cs_n_d) begin
               // select fall: pick mode from idle clock, start opcode
               next_r.mode3 = sclk_s;                     // R3
               next_r.st    = SFPM_ST_OPCODE;             // R2
               next_r.cnt   = 5'h0;
            end else if (r.st == SFPM_ST_STANDBY) begin
               next_r.st = SFPM_ST_STANDBY;               // R2
            end else if (sample) begin
               next_r.sh  = {r.sh[`SFPM_ADDR_W-2:0], si_s};
               next_r.cnt = r.cnt + 5'h1;
               case (r.st)
                  SFPM_ST_OPCODE: begin
                     if (r.cnt == 5'h7) begin
                        next_r.cnt = 5'h0;
                        next_r.st  = ({r.sh[6:0], si_s} == `SFPM_OP_CONT_READ)
                                     ? SFPM_ST_ADDR : SFPM_ST_IGNORE;
                     end
                  end
                  SFPM_ST_ADDR: begin
                     if (r.cnt == 5'(`SFPM_ADDR_W - 1)) begin
                        // top bit dropped, page then offset
                        next_r.page   = r.sh[`SFPM_ADDR_W-3:`SFPM_BYTE_W-1]; // R8 R9
                        next_r.offs   = {r.sh[`SFPM_BYTE_W-2:0], si_s};      // R9
                        next_r.rd_req = 1'b1;
                        next_r.cnt    = 5'h0;
                        next_r.dcnt   = 2'h0;
                        next_r.st     = SFPM_ST_DUMMY;
                     end
                  end
                  SFPM_ST_DUMMY: begin
                     if (r.cnt == 5'h7) begin
                        next_r.cnt  = 5'h0;
                        next_r.dcnt = r.dcnt + 2'h1;
                        if (r.dcnt == 2'(`SFPM_DUMMY_BYTES - 1)) begin
                           next_r.st       = SFPM_ST_DATA;        // R10
                           next_r.obuf     = rd_data_i;
                           next_r.byte_req = 1'b1;
                        end
                     end
                  end
                  SFPM_ST_DATA: begin
                     if (r.cnt == 5'h7) begin
                        next_r.cnt      = 5'h0;
                        next_r.obuf     = rd_data_i;
                        next_r.byte_req = 1'b1;
                     end
                  end
                  default: begin
                     next_r.cnt = 5'h0;
                  end
               endcase
            end else if (launch && r.st == SFPM_ST_DATA) begin
               // drive the msb pending for the next rising edge
               next_r.oe   = 1'b1;
               next_r.so   = r.obuf[7];
               next_r.obuf = {r.obuf[6:0], 1'b0};
            end
         end
      endcase
   end

   // state register; reset leaves mode 3 and a floating output
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         r       <= '0;
         r.st    <= SFPM_ST_POR;
         r.mode3 <= 1'b1;                                 // R1
         r.cs_n_d <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign so_o       = r.so;
   assign so_oe_o    = r.oe;                              // R1
   assign mode3_o    = r.mode3;
   assign standby_o  = (r.st == SFPM_ST_STANDBY);
   assign write_ok_o = r.wok;
   assign rd_req_o   = r.rd_req;
   assign rd_page_o  = r.page;
   assign rd_byte_o  = r.offs;
   assign byte_req_o = r.byte_req;

   AST_NO_DRIVE_DESELECTED: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (cs_n_s && r.cs_n_d) |=> !so_oe_o) else $error("output driven while deselected"); // R1
   AST_MODE_AT_SELECT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (!cs_n_s && r.cs_n_d && r.st != SFPM_ST_POR) |=> (mode3_o == $past(sclk_s)))
      else $error("mode not taken from idle clock"); // R3
   AST_START_ON_FALL: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (r.st == SFPM_ST_STANDBY && !(r.cs_n_d && !cs_n_s)) |=> standby_o)
      else $error("command began without select fall"); // R2
   AST_POR_IGNORES: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (r.st == SFPM_ST_POR) |=> !rd_req_o && !so_oe_o) else $error("active during reset"); // R5
   AST_STANDBY_AFTER_POR: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (r.st == SFPM_ST_POR && r.por_done && cs_n_s) |=> standby_o)
      else $error("no standby after power-up"); // R7
   AST_ADDR_FRAME: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      rd_req_o |-> r.st == SFPM_ST_DUMMY && r.dcnt == 2'h0) else $error("address framing"); // R8
   AST_PAGE_STABLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !rd_req_o && !$past(rd_req_o) |-> $stable(rd_page_o)) else $error("page changed"); // R9
   AST_DUMMY_FIRST: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (r.st == SFPM_ST_DUMMY) |-> !so_oe_o) else $error("data during dummy bytes"); // R10
endmodule // sfpm_front

// ### bench/sfpm_host_model.sv
/* host spi master model: one select-framed command, address, dummies, reads.
   assumes a 200 ns serial clock and a device sampling on rising sclk. */
`timescale 1ns/10ps
module sfpm_host_model (
   output logic      sclk_o, // serial clock, still outside frames
   output logic      cs_n_o, // select, low active
   output logic      si_o,   // serial data to the device
   input  wire logic so_i    // serial data from the device
);
   // bus idle until the first frame
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end
   // opcode, 24 address bits, 32 dummy bits, then two bytes read back
   task automatic frame(input logic idle_hi, input logic [7:0] op,
                        input logic [23:0] addr, output logic [15:0] got);
      logic [63:0] tx;
      tx = {op, addr, 32'h0};
      sclk_o = idle_hi; // idle level chooses the mode
      #137;
      cs_n_o = 1'b0; // each command opens with a select fall
      #100; // idle clock must still stand when the device sees the fall
      for (int i = 63; i >= 0; i--) begin
         sclk_o = 1'b0;
         si_o   = tx[i]; // msb first: opcode, x, page, byte, then dummies
         #100;
         sclk_o = 1'b1;
         #100;
      end
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         #100;
         got[i] = so_i; // taken at the rising edge
         sclk_o = 1'b1;
         #100;
      end
      sclk_o = idle_hi;
      #100;
      cs_n_o = 1'b1;
      si_o   = ~si_o; // released line shows the inverse of its last value
      #500;
   endtask
endmodule // sfpm_host_model

// ### bench/tb.sv
/* bench for the flash front end: reset, reads in both modes, refusals.
   assumes the host model file and a shortened write delay of 50 cycles. */
`timescale 1ns/10ps
`include "sfpm_defines.svh"
module tb;
   logic sys_clk, reset, sclk, cs_n, si, so, so_oe, mode3, standby, write_ok, rd_req, byte_req;
   logic [`SFPM_PAGE_W-1:0] rd_page;
   logic [`SFPM_BYTE_W-1:0] rd_byte;
   logic [7:0]              rd_data;
   logic [15:0]             got;
   int                      mismatches, n_checks, cycles, n_req, n_oe;
   sfpm_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
   sfpm_front #(.WRITE_DELAY_CYC(50)) dut (.sys_clk_i(sys_clk), .reset_i(reset),
      .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
      .mode3_o(mode3), .standby_o(standby), .write_ok_o(write_ok), .rd_req_o(rd_req),
      .rd_page_o(rd_page), .rd_byte_o(rd_byte), .byte_req_o(byte_req), .rd_data_i(rd_data));
   // system clock
   always #12.5 sys_clk = ~sys_clk;
   // hang guard, pulse counters, next data byte on each request
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
      if (rd_req === 1'b1) n_req++;
      if (so_oe === 1'b1) n_oe++;
      if (byte_req === 1'b1) rd_data <= #2 rd_data + 8'h11;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // reset values, standby, then the write window opens after 50 cycles
   task automatic t_reset();
      check("so_oe", 0, so_oe);
      check("mode3", 1, mode3);
      @(posedge sys_clk) #2 reset = 1'b0;
      repeat (20) @(posedge sys_clk);
      check("standby", 1, standby);
      check("write_ok early", 0, write_ok);
      repeat (40) @(posedge sys_clk);
      check("write_ok", 1, write_ok);
   endtask
   // continuous read: address fields, mode pick, dummies, data stream
   task automatic t_read(input logic idle_hi, input logic [23:0] addr);
      n_req = 0;
      rd_data = 8'h3c;
      host.frame(idle_hi, 8'he8, addr, got);
      check("mode3", 32'(idle_hi), mode3);
      check("rd_req count", 1, n_req);
      check("rd_page", 32'(addr[22:10]), rd_page);
      check("rd_byte", 32'(addr[9:0]), rd_byte);
      check("data", 32'h3c4d, got);
      check("so_oe idle", 0, so_oe);
      check("standby", 1, standby);
   endtask
   // a foreign opcode never reaches the read path
   task automatic t_bad_op();
      n_req = 0;
      n_oe = 0;
      host.frame(1'b1, 8'hd2, 24'h00_0400, got);
      check("rd_req count", 0, n_req);
      check("so_oe count", 0, n_oe);
   endtask
   // a full read frame while reset is held is ignored
   task automatic t_por();
      @(posedge sys_clk) #2 reset = 1'b1;
      n_req = 0;
      n_oe = 0;
      host.frame(1'b0, 8'he8, 24'h00_0001, got);
      check("rd_req count", 0, n_req);
      check("so_oe count", 0, n_oe);
      check("mode3", 1, mode3);
      @(posedge sys_clk) #2 reset = 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask
   // main sequence
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      rd_data = 8'h00;
      mismatches = 0;
      n_checks = 0;
      cycles = 0;
      repeat (12) @(posedge sys_clk);
      t_reset();
      #70000; // hold select off after power-up
      t_read(1'b1, {1'b1, 13'h1a5c, 10'h3c1});
      t_read(1'b0, {1'b0, 13'h0001, 10'h200});
      t_bad_op();
      t_por();
      stop_test();
   end
endmodule // tb
